// *** ssp_sync_slave.sv ***
// Synchronous slave serial port with Avalon-MM register access
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ssp_sync_slave #(
	parameter int FIFO_DEPTH = ssp_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                        i_clk,
	input  wire logic                        i_nrst,
	// Avalon-MM slave
	input  wire logic [ssp_pkg::ADDR_W-1:0]  i_address,
	input  wire logic                        i_read,
	input  wire logic                        i_write,
	input  wire logic [ssp_pkg::DATA_W-1:0]  i_writedata,
	input  wire logic [ssp_pkg::BE_W-1:0]    i_byteenable,
	output logic      [ssp_pkg::DATA_W-1:0]  o_readdata,
	output logic                             o_waitrequest,
	// Serial clock pin
	input  wire logic                        i_ck_in,
	output logic                             o_ck_out,
	output logic                             o_ck_oe,
	// Serial data pin
	input  wire logic                        i_dt_in,
	output logic                             o_dt_out,
	output logic                             o_dt_oe,
	// Core power state and wake
	input  wire logic                        i_sleep,
	output logic                             o_wake,
	output logic                             o_isr_branch
);
	import ssp_pkg::*;

	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int FW = $clog2(FIFO_DEPTH + 1);
	localparam logic [FW-1:0] FIFO_FULL = FW'(FIFO_DEPTH);
	localparam logic [PW-1:0] PTR_LAST  = PW'(FIFO_DEPTH - 1);

	logic [7:0]           tx_status_reg, rx_status_reg, baud_reg, int_ctrl_reg;
	logic                 ck_s, dt_s, ck_prev_reg, ck_lvl, lead, trail;
	logic                 accept, wr_en, rd_en, wr_txdata, pop;
	logic [7:0]           rd_mux;
	logic                 port_enable, continuous_receive_enable, tx_mode, rx_mode;
	logic [CNT_W-1:0]     tx_bits, rx_bits;
	ssp_tx_state_type     tx_state_reg;
	logic [CHAR_W-1:0]    hold_reg, tsr_reg, rsr_reg, rx_char;
	logic                 hold_full_reg, started_reg, load;
	logic [CNT_W-1:0]     tx_cnt_reg, rx_cnt_reg;
	logic [CHAR_W-1:0]    fifo_reg [FIFO_DEPTH];
	logic [PW-1:0]        wr_ptr_reg, rd_ptr_reg;
	logic [FW-1:0]        fifo_cnt_reg;
	logic                 overrun_reg, rx_last, push;
	logic                 transmit_ready_flag, receive_ready_flag, shift_register_empty, tx_ev, rx_ev;

	// Pins come from the master's domain
	ssp_sync2 #(.W(2)) u_sync (
		.i_clk (i_clk),
		.i_nrst(i_nrst),
		.i_d   ({i_ck_in, i_dt_in}),
		.o_q   ({ck_s, dt_s})
	);

	// Clock edges after polarity select
	assign ck_lvl = ck_s ^ baud_reg[BC_CLK_POL];
	assign lead   = ck_lvl & ~ck_prev_reg;
	assign trail  = ~ck_lvl & ck_prev_reg;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ck_prev_reg <= 1'b0;
		end else begin
			ck_prev_reg <= ck_lvl;
		end
	end

	// Mode decode; single receive enable only blocks transmit, receive ignores it
	assign port_enable    = rx_status_reg[RS_PORT_EN];
	assign continuous_receive_enable    = rx_status_reg[RS_CONT];
	assign tx_mode = port_enable & tx_status_reg[TS_TX_EN] & ~continuous_receive_enable & ~rx_status_reg[RS_SINGLE];
	assign rx_mode = port_enable & continuous_receive_enable & ~overrun_reg;
	assign tx_bits = tx_status_reg[TS_NINE] ? CNT_W'(CHAR_W) : CNT_W'(BYTE_W);
	assign rx_bits = rx_status_reg[RS_NINE] ? CNT_W'(CHAR_W) : CNT_W'(BYTE_W);

	// Status terms
	assign transmit_ready_flag  = ~hold_full_reg;
	assign receive_ready_flag  = (fifo_cnt_reg != '0);
	assign shift_register_empty  = (tx_state_reg != TX_SHIFT);
	assign tx_ev = transmit_ready_flag & int_ctrl_reg[IC_TX_EN] & int_ctrl_reg[IC_PERIPH_EN];
	assign rx_ev = receive_ready_flag & int_ctrl_reg[IC_RX_EN];

	// Bus strobes: a request takes effect on the edge where waitrequest is low
	assign accept    = ~o_waitrequest & (i_read | i_write);
	assign wr_en     = accept & i_write & i_byteenable[0];
	assign rd_en     = accept & i_read;
	assign wr_txdata = wr_en & (i_address == OFF_TX_DATA);
	assign pop       = rd_en & (i_address == OFF_RX_DATA) & receive_ready_flag;

	// Read mux; status bits are live, unmapped offsets read zero
	always_comb begin
		rd_mux = 8'h00;
		case (i_address)
			OFF_TX_STATUS: begin
				rd_mux           = tx_status_reg;
				rd_mux[TS_EMPTY] = shift_register_empty;
			end
			OFF_RX_STATUS: begin
				rd_mux               = rx_status_reg;
				rd_mux[RS_FRAME_ERR] = 1'b0;
				rd_mux[RS_OVERRUN]   = overrun_reg;
				rd_mux[RS_NINTH]     = fifo_reg[rd_ptr_reg][BYTE_W];
			end
			OFF_RX_DATA:   rd_mux = fifo_reg[rd_ptr_reg][BYTE_W-1:0];
			OFF_BAUD: begin
				rd_mux             = baud_reg;
				rd_mux[BC_RX_IDLE] = (rx_cnt_reg == '0);
			end
			OFF_INT_CTRL: begin
				rd_mux             = int_ctrl_reg;
				rd_mux[IC_RX_FLAG] = receive_ready_flag;
				rd_mux[IC_TX_FLAG] = transmit_ready_flag;
			end
			default:       rd_mux = 8'h00;
		endcase
	end

	// One wait cycle per access, then a single answer cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_waitrequest <= 1'b1;
			o_readdata    <= '0;
		end else if ((i_read | i_write) & o_waitrequest) begin
			o_waitrequest <= 1'b0;
			o_readdata    <= i_read ? {24'h000000, rd_mux} : '0;
		end else begin
			o_waitrequest <= 1'b1;
		end
	end

	// Software-written control registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_status_reg <= TX_STATUS_RST;
			rx_status_reg <= RX_STATUS_RST;
			baud_reg      <= BAUD_RST;
			int_ctrl_reg  <= INT_CTRL_RST;
		end else if (wr_en) begin
			case (i_address)
				OFF_TX_STATUS: tx_status_reg <= i_writedata[7:0];
				OFF_RX_STATUS: rx_status_reg <= i_writedata[7:0];
				OFF_BAUD:      baud_reg      <= i_writedata[7:0];
				OFF_INT_CTRL:  int_ctrl_reg  <= i_writedata[7:0];
				default:       int_ctrl_reg  <= int_ctrl_reg;
			endcase
		end
	end

	// Holding register takes the ninth bit from the status register at write
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hold_reg <= '0;
		end else if (wr_txdata) begin
			hold_reg <= {tx_status_reg[TS_NINTH], i_writedata[BYTE_W-1:0]};
		end
	end

	assign load = (tx_state_reg == TX_IDLE) & hold_full_reg & tx_mode;

	// Transmit shifter; Sleep changes nothing here, the clock is the master's
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_state_reg  <= TX_IDLE;
			hold_full_reg <= 1'b0;
			tsr_reg       <= '0;
			tx_cnt_reg    <= '0;
			started_reg   <= 1'b0;
			o_dt_out      <= 1'b0;
			o_dt_oe       <= 1'b0;
		end else if (!port_enable) begin
			tx_state_reg  <= TX_IDLE;
			hold_full_reg <= 1'b0;
			tx_cnt_reg    <= '0;
			started_reg   <= 1'b0;
			o_dt_out      <= 1'b0;
			o_dt_oe       <= 1'b0;
		end else begin
			// A write in the load cycle keeps the holding register full
			hold_full_reg <= (hold_full_reg & ~load) | wr_txdata;
			o_dt_oe       <= tx_mode;
			case (tx_state_reg)
				TX_IDLE: begin
					if (load) begin
						tsr_reg      <= hold_reg;
						o_dt_out     <= hold_reg[0];
						tx_cnt_reg   <= '0;
						started_reg  <= 1'b0;
						tx_state_reg <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					// First bit is already out; later bits change on leading edges
					if (lead) begin
						started_reg <= 1'b1;
						if (started_reg) begin
							o_dt_out <= tsr_reg[tx_cnt_reg];
						end
					end
					if (trail) begin
						tx_cnt_reg <= tx_cnt_reg + 1'b1;
						if (tx_cnt_reg == tx_bits - 1'b1) begin
							tx_state_reg <= TX_DONE;
						end
					end
				end
				TX_DONE:  tx_state_reg <= TX_IDLE;
				default:  tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// Character being completed, with the bit sampled this edge merged in
	always_comb begin
		rx_char             = rsr_reg;
		rx_char[rx_cnt_reg] = dt_s;
		if (!rx_status_reg[RS_NINE]) begin
			rx_char[BYTE_W] = 1'b0;
		end
	end
	assign rx_last = rx_mode & trail & (rx_cnt_reg == rx_bits - 1'b1);
	assign push    = rx_last & ((fifo_cnt_reg != FIFO_FULL) | pop);

	// Receive shifter, two-deep buffer and overrun
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rsr_reg      <= '0;
			rx_cnt_reg   <= '0;
			wr_ptr_reg   <= '0;
			rd_ptr_reg   <= '0;
			fifo_cnt_reg <= '0;
			overrun_reg  <= 1'b0;
			fifo_reg     <= '{default: '0};
		end else if (!port_enable) begin
			rx_cnt_reg   <= '0;
			wr_ptr_reg   <= '0;
			rd_ptr_reg   <= '0;
			fifo_cnt_reg <= '0;
			overrun_reg  <= 1'b0;
		end else begin
			if (!continuous_receive_enable) begin
				rx_cnt_reg  <= '0;
				overrun_reg <= 1'b0;
			end else if (rx_mode & trail) begin
				rsr_reg <= rx_char;
				rx_cnt_reg <= rx_last ? '0 : rx_cnt_reg + 1'b1;
				if (rx_last & ~push) begin
					overrun_reg <= 1'b1;
				end
			end
			if (push) begin
				fifo_reg[wr_ptr_reg] <= rx_char;
				wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
			end
			fifo_cnt_reg <= fifo_cnt_reg + FW'(push) - FW'(pop);
		end
	end

	// Wake and branch requests to the core; clock pin is never driven
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_wake       <= 1'b0;
			o_isr_branch <= 1'b0;
			o_ck_out     <= 1'b0;
			o_ck_oe      <= 1'b0;
		end else begin
			o_wake       <= i_sleep & (tx_ev | rx_ev);
			o_isr_branch <= int_ctrl_reg[IC_GLOBAL_EN] & (tx_ev | rx_ev);
			o_ck_out     <= 1'b0;
			o_ck_oe      <= 1'b0;
		end
	end

	a_ck_driver_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(port_enable ##1 port_enable) |-> !o_ck_oe) else $error("clock pin driven in slave");
	a_first_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
		load |=> (tx_state_reg == TX_SHIFT) && (tsr_reg == $past(hold_reg)))
		else $error("first character not loaded");
	a_second_held: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(tx_state_reg == TX_SHIFT && hold_full_reg && port_enable) |=> hold_full_reg)
		else $error("second character left holding early");
	a_reload_after: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(tx_state_reg == TX_DONE && hold_full_reg && tx_mode) ##1 tx_mode
		|=> (tx_state_reg == TX_SHIFT) && transmit_ready_flag) else $error("no reload after shift out");
	a_tx_wake: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_sleep && transmit_ready_flag && int_ctrl_reg[IC_TX_EN] && int_ctrl_reg[IC_PERIPH_EN]) |=> o_wake)
		else $error("transmit flag did not wake");
	a_rx_branch: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(rx_ev && int_ctrl_reg[IC_GLOBAL_EN]) |=> o_isr_branch)
		else $error("no branch on received character");
	a_rx_push: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(rx_last && fifo_cnt_reg == '0) |=> receive_ready_flag && fifo_cnt_reg == FW'(1))
		else $error("received character not buffered");
	a_overrun_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(rx_last && fifo_cnt_reg == FIFO_FULL && !pop)
		|=> overrun_reg && fifo_cnt_reg == FIFO_FULL) else $error("overrun not flagged");
	a_port_reset: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!port_enable |=> (fifo_cnt_reg == '0) && !overrun_reg && (tx_state_reg == TX_IDLE))
		else $error("port not reset by enable clear");
endmodule : ssp_sync_slave
`default_nettype wire

// *** ssp_pkg.sv ***
// Constants, register map and types for the synchronous serial slave port
package ssp_pkg;
	// Bus geometry
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_TX_STATUS = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_RX_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_TX_DATA   = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_RX_DATA   = 5'h0c;
	localparam logic [ADDR_W-1:0] OFF_BAUD      = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_INT_CTRL  = 5'h14;

	// transmit_status_control fields
	localparam int TS_CLK_MASTER = 7;
	localparam int TS_NINE       = 6;
	localparam int TS_TX_EN      = 5;
	localparam int TS_EMPTY      = 1;
	localparam int TS_NINTH      = 0;

	// receive_status_control fields
	localparam int RS_PORT_EN    = 7;
	localparam int RS_NINE       = 6;
	localparam int RS_SINGLE     = 5;
	localparam int RS_CONT       = 4;
	localparam int RS_FRAME_ERR  = 2;
	localparam int RS_OVERRUN    = 1;
	localparam int RS_NINTH      = 0;

	// baud_control fields
	localparam int BC_RX_IDLE    = 6;
	localparam int BC_CLK_POL    = 4;

	// Interrupt control fields
	localparam int IC_GLOBAL_EN  = 7;
	localparam int IC_PERIPH_EN  = 6;
	localparam int IC_RX_EN      = 5;
	localparam int IC_TX_EN      = 4;
	localparam int IC_RX_FLAG    = 3;
	localparam int IC_TX_FLAG    = 2;

	// Reset values
	localparam logic [7:0] TX_STATUS_RST = 8'h00;
	localparam logic [7:0] RX_STATUS_RST = 8'h00;
	localparam logic [7:0] BAUD_RST      = 8'h00;
	localparam logic [7:0] INT_CTRL_RST  = 8'h00;

	// Character geometry
	localparam int BYTE_W     = 8;
	localparam int CHAR_W     = 9;
	localparam int FIFO_DEPTH = 2;
	localparam int CNT_W      = 4;

	// Transmit shifter states
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SHIFT = 2'b01,
		TX_DONE  = 2'b11
	} ssp_tx_state_type;
endpackage : ssp_pkg

// *** ssp_sync2.sv ***
// Two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/10ps
`default_nettype none
module ssp_sync2 #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	// Asynchronous input and synchronised output
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_reg <= '0;
			o_q      <= '0;
		end else begin
			meta_reg <= i_d;
			o_q      <= meta_reg;
		end
	end
endmodule : ssp_sync2
`default_nettype wire

// *** ssp_master_model.sv ***
// Behavioural external synchronous master that clocks the serial port
`timescale 1ns/10ps
`default_nettype none
module ssp_master_model (
	// Resolved data line
	input  wire logic i_dt,
	// Clock and data driven by the master
	output logic      o_ck,
	output logic      o_dt
);
	// Clock stands low between frames; it never runs free
	initial begin
		o_ck = 1'b0;
		o_dt = 1'b0;
	end

	// One character, LSB first, 125 ns per bit; returns the bits sampled on the line
	task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
		rx = 9'h000;
		for (int i = 0; i < n; i++) begin
			o_ck = 1'b1;
			o_dt = tx[i];
			#62.5;
			o_ck = 1'b0;
			rx[i] = i_dt;
			#62.5;
		end
		// Released line shows the inverse so a stale bit never looks valid
		o_dt = ~o_dt;
	endtask : xfer
endmodule : ssp_master_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the synchronous slave serial port
`timescale 1ns/10ps
`default_nettype none
module tb;
	import ssp_pkg::*;
	logic                i_clk;
	logic                i_nrst;
	logic [ADDR_W-1:0]   i_address;
	logic                i_read;
	logic                i_write;
	logic [DATA_W-1:0]   i_writedata;
	logic [BE_W-1:0]     i_byteenable;
	logic [DATA_W-1:0]   o_readdata;
	logic                o_waitrequest;
	logic                o_ck_out;
	logic                o_ck_oe;
	logic                o_dt_out;
	logic                o_dt_oe;
	logic                i_sleep;
	logic                o_wake;
	logic                o_isr_branch;
	logic                m_ck;
	logic                m_dt;
	logic                ck_wire;
	logic                dt_wire;
	logic [31:0]         q;
	logic [8:0]          rx;
	int                  n_fail;
	int                  checks;

	// Wire levels from the slave's enables, else the master drives; both pins kept purely digital
	assign ck_wire = o_ck_oe ? o_ck_out : m_ck;
	assign dt_wire = o_dt_oe ? o_dt_out : m_dt;

	ssp_sync_slave #(.FIFO_DEPTH(FIFO_DEPTH)) DUT (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_ck_in(ck_wire),
		.o_ck_out(o_ck_out), .o_ck_oe(o_ck_oe), .i_dt_in(dt_wire), .o_dt_out(o_dt_out),
		.o_dt_oe(o_dt_oe), .i_sleep(i_sleep), .o_wake(o_wake), .o_isr_branch(o_isr_branch)
	);

	ssp_master_model u_m (.i_dt(dt_wire), .o_ck(m_ck), .o_dt(m_dt));

	// 100 MHz core clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic finish_test();
		if (n_fail == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// Avalon cycle: hold everything until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
			output logic [31:0] rd);
		@(posedge i_clk);
		i_write <= wr;
		i_read <= ~wr;
		i_address <= a;
		i_writedata <= {24'h000000, d};
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		rd = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask : wr

	// Bounded wait; the level is compared by the caller
	task automatic wait_wake();
		for (int k = 0; k < 60 && o_wake !== 1'b1; k++) @(posedge i_clk);
	endtask : wait_wake

	// Watchdog sized well above the eight characters sent
	initial begin
		#300000;
		n_fail++;
		finish_test();
	end

	initial begin
		n_fail = 0;
		checks = 0;
		i_nrst = 1'b0;
		i_address = 5'h00;
		i_read = 1'b0;
		i_write = 1'b0;
		i_writedata = 32'h00000000;
		i_byteenable = 4'h1;
		i_sleep = 1'b0;
		repeat (20) @(posedge i_clk);
		i_nrst <= 1'b1;
		// Reset values and an unmapped place
		bus(1'b0, OFF_RX_STATUS, 8'h00, q);
		chk("rx_status_rst", q, {24'h0, RX_STATUS_RST});
		bus(1'b0, 5'h18, 8'h00, q);
		chk("unmapped", q, 32'h00000000);
		// Slave transmit: two characters queued, then Sleep
		wr(OFF_INT_CTRL, 8'h50);
		wr(OFF_RX_STATUS, 8'h80);
		wr(OFF_TX_STATUS, 8'h20);
		repeat (2) @(posedge i_clk);
		chk("ck_oe", o_ck_oe, 1'b0);
		chk("ck_out", o_ck_out, 1'b0);
		chk("dt_oe_tx", o_dt_oe, 1'b1);
		wr(OFF_TX_DATA, 8'ha5);
		wr(OFF_TX_DATA, 8'h3c);
		i_sleep <= 1'b1;
		bus(1'b0, OFF_TX_STATUS, 8'h00, q);
		chk("shifting", q[TS_EMPTY], 1'b0);
		bus(1'b0, OFF_INT_CTRL, 8'h00, q);
		chk("tx_flag_held", q[IC_TX_FLAG], 1'b0);
		chk("no_wake", o_wake, 1'b0);
		u_m.xfer(9'h000, 8, rx);
		chk("tx_char1", rx, 9'h0a5);
		wait_wake();
		chk("wake_tx", o_wake, 1'b1);
		chk("no_isr", o_isr_branch, 1'b0);
		bus(1'b0, OFF_TX_STATUS, 8'h00, q);
		chk("second_loaded", q[TS_EMPTY], 1'b0);
		wr(OFF_INT_CTRL, 8'hd0);
		repeat (2) @(posedge i_clk);
		chk("isr_tx", o_isr_branch, 1'b1);
		u_m.xfer(9'h000, 8, rx);
		chk("tx_char2", rx, 9'h03c);
		repeat (8) @(posedge i_clk);
		bus(1'b0, OFF_TX_STATUS, 8'h00, q);
		chk("empty", q[TS_EMPTY], 1'b1);
		// Nine-bit transmit, ninth bit last
		i_sleep <= 1'b0;
		wr(OFF_TX_STATUS, 8'h61);
		wr(OFF_TX_DATA, 8'h5a);
		u_m.xfer(9'h000, 9, rx);
		chk("tx_nine", rx, 9'h15a);
		// Port enable cleared mid-character resets the port
		wr(OFF_TX_DATA, 8'hff);
		wr(OFF_RX_STATUS, 8'h00);
		repeat (2) @(posedge i_clk);
		chk("dt_oe_off", o_dt_oe, 1'b0);
		// Slave receive during Sleep
		wr(OFF_TX_STATUS, 8'h00);
		wr(OFF_INT_CTRL, 8'h20);
		wr(OFF_RX_STATUS, 8'h90);
		chk("dt_oe_rx", o_dt_oe, 1'b0);
		i_sleep <= 1'b1;
		u_m.xfer(9'h096, 8, rx);
		wait_wake();
		chk("wake_rx", o_wake, 1'b1);
		chk("no_isr_rx", o_isr_branch, 1'b0);
		wr(OFF_INT_CTRL, 8'ha0);
		repeat (2) @(posedge i_clk);
		chk("isr_rx", o_isr_branch, 1'b1);
		bus(1'b0, OFF_INT_CTRL, 8'h00, q);
		chk("rx_flag", q[IC_RX_FLAG], 1'b1);
		bus(1'b0, OFF_RX_DATA, 8'h00, q);
		chk("rx_char", q, 32'h00000096);
		bus(1'b0, OFF_INT_CTRL, 8'h00, q);
		chk("rx_flag_clr", q[IC_RX_FLAG], 1'b0);
		// Single enable set too: ignored; three characters overrun
		i_sleep <= 1'b0;
		wr(OFF_RX_STATUS, 8'hb0);
		u_m.xfer(9'h011, 8, rx);
		u_m.xfer(9'h022, 8, rx);
		u_m.xfer(9'h033, 8, rx);
		repeat (8) @(posedge i_clk);
		bus(1'b0, OFF_RX_STATUS, 8'h00, q);
		chk("overrun", q, 32'h000000b2);
		bus(1'b0, OFF_RX_DATA, 8'h00, q);
		chk("rx_first", q, 32'h00000011);
		bus(1'b0, OFF_RX_DATA, 8'h00, q);
		chk("rx_second", q, 32'h00000022);
		wr(OFF_RX_STATUS, 8'ha0);
		bus(1'b0, OFF_RX_STATUS, 8'h00, q);
		chk("overrun_clr", q, 32'h000000a0);
		// Nine-bit receive: ninth bit read before the low byte
		wr(OFF_RX_STATUS, 8'hd0);
		u_m.xfer(9'h1c3, 9, rx);
		repeat (8) @(posedge i_clk);
		bus(1'b0, OFF_RX_STATUS, 8'h00, q);
		chk("rx_ninth", q[RS_NINTH], 1'b1);
		bus(1'b0, OFF_RX_DATA, 8'h00, q);
		chk("rx_nine_low", q, 32'h000000c3);
		finish_test();
	end
endmodule : tb
`default_nettype wire
